// File: logic/ops_pkg.sv
// Constants for the display power and reset sequencer
package ops_pkg;
  localparam int          OPS_ADDR_W      = 3;
  localparam int          OPS_DATA_W      = 32;
  localparam logic [2:0]  OPS_REG_CMD     = 3'h0;
  localparam logic [2:0]  OPS_REG_STATUS  = 3'h1;
  localparam logic [2:0]  OPS_REG_CONFIG  = 3'h2;
  localparam logic [2:0]  OPS_REG_SERIAL  = 3'h3;
  localparam logic [2:0]  OPS_REG_DATA    = 3'h4;
  localparam int          OPS_ST_DISP     = 0;
  localparam int          OPS_ST_SEG      = 1;
  localparam int          OPS_ST_COM      = 2;
  localparam int          OPS_ST_ENTIRE   = 3;
  localparam int          OPS_ST_INRST    = 4;
  localparam int          OPS_ST_ARGWAIT  = 5;
  localparam int          OPS_ST_CONTR_LO = 8;
  localparam int          OPS_ST_START_LO = 16;
  localparam int          OPS_CF_MUX_LO   = 8;
  localparam int          OPS_CF_COLS_LO  = 16;
  localparam logic [7:0]  OPS_RST_CONTR   = 8'h7F;
  localparam logic [5:0]  OPS_RST_START   = 6'h00;
  localparam logic [6:0]  OPS_RST_COL     = 7'h00;
  localparam logic [5:0]  OPS_MUX_ROWS_M1 = 6'h3F;
  localparam logic [7:0]  OPS_COLS        = 8'h80;
  localparam logic [6:0]  OPS_COL_LAST    = 7'h7F;
  localparam logic [7:0]  OPS_CMD_OFF     = 8'hAE;
  localparam logic [7:0]  OPS_CMD_ON      = 8'hAF;
  localparam logic [7:0]  OPS_CMD_NORMAL  = 8'hA4;
  localparam logic [7:0]  OPS_CMD_ENTIRE  = 8'hA5;
  localparam logic [7:0]  OPS_CMD_FIRST_SEGMENT_OUTPUT    = 8'hA0;
  localparam logic [7:0]  OPS_CMD_SEG1    = 8'hA1;
  localparam logic [7:0]  OPS_CMD_COMNRM  = 8'hC0;
  localparam logic [7:0]  OPS_CMD_COMREV  = 8'hC8;
  localparam logic [7:0]  OPS_CMD_CONTR   = 8'h81;
  localparam logic [1:0]  OPS_START_TOP   = 2'h1;
  localparam int          OPS_SER_BITS    = 8;
  typedef enum logic [1:0] {
    OPS_IDLE    = 2'b00,
    OPS_ARG     = 2'b01
  } ops_state_t;
endpackage

// File: logic/ops_serial_rx.sv
// Serial command shift register, eight bits MSB first on rising clock
`timescale 1ns/10ps
module ops_serial_rx #(
  parameter int BITS = ops_pkg::OPS_SER_BITS
) (
  input  wire logic            core_clk,
  input  wire logic            clear,
  input  wire logic            ser_clk_s,
  input  wire logic            ser_data_s,
  input  wire logic            ser_sel_n_s,
  output logic                 byte_valid,
  output logic [BITS-1:0]      byte_data
);
  import ops_pkg::*;
  logic                        clk_d;
  logic [BITS-1:0]             shift;
  logic [$clog2(BITS+1)-1:0]   count;
  logic                        next_clk_d;
  logic [BITS-1:0]             next_shift;
  logic [$clog2(BITS+1)-1:0]   next_count;
  logic                        next_byte_valid;
  logic [BITS-1:0]             next_byte_data;

  always_comb begin
    next_clk_d      = ser_clk_s;
    next_shift      = shift;
    next_count      = count;
    next_byte_valid = 1'b0;
    next_byte_data  = byte_data;
    if (ser_sel_n_s) begin
      next_count = '0;
    end else if (ser_clk_s && !clk_d) begin
      next_shift = {shift[BITS-2:0], ser_data_s};
      if (count == ($clog2(BITS+1))'(BITS - 1)) begin
        next_count      = '0;
        next_byte_valid = 1'b1;
        next_byte_data  = {shift[BITS-2:0], ser_data_s};
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear) begin
      clk_d      <= 1'b0;
      shift      <= '0;
      count      <= '0;
      byte_valid <= 1'b0;
      byte_data  <= '0;
    end else begin
      clk_d      <= next_clk_d;
      shift      <= next_shift;
      count      <= next_count;
      byte_valid <= next_byte_valid;
      byte_data  <= next_byte_data;
    end
  end
endmodule

// File: logic/ops_sequencer.sv
// Display driver reset defaults, command state and Avalon register slave
// Operation
// - While reset pin is low the device holds defaults, display off.
// - Reset selects full 128 by 64 display mode.
// - Reset selects unremapped segment and common mapping from address zero.
// - Reset clears the serial interface shift register.
// - Reset sets display start line to memory address zero.
// - Reset clears the column address counter to zero.
// - Reset sets normal common scan direction.
// - Reset loads contrast value 7Fh.
// - Reset selects normal display mode, as command A4h.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module ops_sequencer
  import ops_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic [ops_pkg::OPS_ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [ops_pkg::OPS_DATA_W-1:0] avs_writedata,
  output logic      [ops_pkg::OPS_DATA_W-1:0] avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          chip_init_in_n,
  input  wire logic                          ser_clk,
  input  wire logic                          ser_data,
  input  wire logic                          ser_sel_n,
  output logic                               display_on,
  output logic                               entire_on,
  output logic                               seg_remap,
  output logic                               com_reverse,
  output logic      [7:0]                    contrast,
  output logic      [5:0]                    start_line,
  output logic      [6:0]                    col_addr,
  output logic      [5:0]                    mux_ratio
);
  import ops_pkg::*;

  logic [3:0]       pin_raw;
  logic [3:0]       sync1;
  logic [3:0]       sync2;
  logic             in_reset;
  logic             clear;
  logic             ser_valid;
  logic [7:0]       ser_byte;
  logic [7:0]       last_serial;
  logic             ack;
  ops_state_t       state;
  logic             bus_cmd;
  logic             bus_data;
  logic             cmd_valid;
  logic [7:0]       cmd_byte;
  logic             next_ack;
  logic [31:0]      next_readdata;
  ops_state_t       next_state;
  logic             next_display_on;
  logic             next_entire_on;
  logic             next_seg_remap;
  logic             next_com_reverse;
  logic [7:0]       next_contrast;
  logic [5:0]       next_start_line;
  logic [6:0]       next_col_addr;
  logic [7:0]       next_last_serial;

  function automatic logic is_start_line(input logic [7:0] b);
    return b[7:6] == OPS_START_TOP;
  endfunction

  // Pins pass two flops before use
  assign pin_raw = {chip_init_in_n, ser_clk, ser_data, ser_sel_n};
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          // Idle levels: reset pin and select high, so no false device reset
          sync1[i] <= (i == 0 || i == 3) ? 1'b1 : 1'b0;
          sync2[i] <= (i == 0 || i == 3) ? 1'b1 : 1'b0;
        end else begin
          sync1[i] <= pin_raw[i];
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate

  // held in defaults while pin low
  assign in_reset = ~sync2[3];
  assign clear    = rst | in_reset;

  ops_serial_rx #(
    .BITS        (OPS_SER_BITS)
  ) ops_serial_rx_i (
    .core_clk    (core_clk),
    .clear       (clear),
    .ser_clk_s   (sync2[2]),
    .ser_data_s  (sync2[1]),
    .ser_sel_n_s (sync2[0]),
    .byte_valid  (ser_valid),
    .byte_data   (ser_byte)
  );

  // One wait cycle on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign bus_cmd   = avs_write & ack & (avs_address == OPS_REG_CMD) & ~in_reset;
  assign bus_data  = avs_write & ack & (avs_address == OPS_REG_DATA) & ~in_reset;
  assign cmd_valid = bus_cmd | ser_valid;
  assign cmd_byte  = bus_cmd ? avs_writedata[7:0] : ser_byte;
  assign mux_ratio = OPS_MUX_ROWS_M1;

  always_comb begin
    next_ack      = (avs_read | avs_write) & ~ack;
    next_readdata = '0;
    case (avs_address)
      OPS_REG_STATUS: begin
        next_readdata[OPS_ST_DISP]    = display_on;
        next_readdata[OPS_ST_SEG]     = seg_remap;
        next_readdata[OPS_ST_COM]     = com_reverse;
        next_readdata[OPS_ST_ENTIRE]  = entire_on;
        next_readdata[OPS_ST_INRST]   = in_reset;
        next_readdata[OPS_ST_ARGWAIT] = (state == OPS_ARG);
        next_readdata[OPS_ST_CONTR_LO +: 8] = contrast;
        next_readdata[OPS_ST_START_LO +: 6] = start_line;
      end
      OPS_REG_CONFIG: begin
        next_readdata[6:0]                  = col_addr;
        next_readdata[OPS_CF_MUX_LO +: 6]   = mux_ratio;
        next_readdata[OPS_CF_COLS_LO +: 8]  = OPS_COLS;
      end
      OPS_REG_SERIAL: begin
        next_readdata[7:0] = last_serial;
      end
      default: begin
        next_readdata = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack          <= 1'b0;
      avs_readdata <= '0;
    end else begin
      ack          <= next_ack;
      if (next_ack && avs_read) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  always_comb begin
    next_state       = state;
    next_display_on  = display_on;
    next_entire_on   = entire_on;
    next_seg_remap   = seg_remap;
    next_com_reverse = com_reverse;
    next_contrast    = contrast;
    next_start_line  = start_line;
    next_col_addr    = col_addr;
    next_last_serial = ser_valid ? ser_byte : last_serial;
    if (bus_data) begin
      next_col_addr = (col_addr == OPS_COL_LAST) ? '0 : col_addr + 1'b1;
    end
    if (cmd_valid) begin
      case (state)
        OPS_ARG: begin
          next_contrast = cmd_byte;
          next_state    = OPS_IDLE;
        end
        OPS_IDLE: begin
          if (cmd_byte == OPS_CMD_OFF) next_display_on = 1'b0;
          if (cmd_byte == OPS_CMD_ON) next_display_on = 1'b1;
          if (cmd_byte == OPS_CMD_NORMAL) next_entire_on = 1'b0;
          if (cmd_byte == OPS_CMD_ENTIRE) next_entire_on = 1'b1;
          if (cmd_byte == OPS_CMD_FIRST_SEGMENT_OUTPUT) next_seg_remap = 1'b0;
          if (cmd_byte == OPS_CMD_SEG1) next_seg_remap = 1'b1;
          if (cmd_byte == OPS_CMD_COMNRM) next_com_reverse = 1'b0;
          if (cmd_byte == OPS_CMD_COMREV) next_com_reverse = 1'b1;
          if (cmd_byte == OPS_CMD_CONTR) next_state = OPS_ARG;
          if (is_start_line(cmd_byte)) next_start_line = cmd_byte[5:0];
        end
        default: begin
          next_state = OPS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear) begin
      state       <= OPS_IDLE;
      display_on  <= 1'b0;
      entire_on   <= 1'b0;
      seg_remap   <= 1'b0;
      com_reverse <= 1'b0;
      contrast    <= OPS_RST_CONTR;
      start_line  <= OPS_RST_START;
      col_addr    <= OPS_RST_COL;
      last_serial <= '0;
    end else begin
      state       <= next_state;
      display_on  <= next_display_on;
      entire_on   <= next_entire_on;
      seg_remap   <= next_seg_remap;
      com_reverse <= next_com_reverse;
      contrast    <= next_contrast;
      start_line  <= next_start_line;
      col_addr    <= next_col_addr;
      last_serial <= next_last_serial;
    end
  end
endmodule

// File: verification/ops_host_model.sv
// Host side serial command sender driving the display controller pins
`timescale 1ns/10ps
module ops_host_model (
  input  wire logic core_clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_sel_n
);
  initial begin
    ser_clk   = 1'b0;
    ser_data  = 1'b0;
    ser_sel_n = 1'b1;
  end
  task automatic send(input logic [7:0] val, input int nbits, input bit keep_sel);
    for (int i = 7; i > 7 - nbits; i--) begin
      repeat (4) @(posedge core_clk);
      ser_sel_n <= 1'b0;
      ser_data  <= val[i];
      repeat (4) @(posedge core_clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      ser_clk <= 1'b0;
    end
    ser_sel_n <= ~keep_sel;
    // Released data line shows the opposite level
    ser_data  <= ~ser_data;
  endtask
endmodule

// File: verification/ops_sequencer_properties.sv
// Port assertions for the display sequencer
`timescale 1ns/10ps
module ops_sequencer_properties (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [2:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        chip_init_in_n,
  input wire logic        display_on,
  input wire logic        entire_on,
  input wire logic        seg_remap,
  input wire logic        com_reverse,
  input wire logic [7:0]  contrast,
  input wire logic [5:0]  start_line,
  input wire logic [6:0]  col_addr,
  input wire logic [5:0]  mux_ratio
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence held_low;
    !chip_init_in_n [*3];
  endsequence
  a_display_off: assert property (held_low |=> !display_on)
    else $error("display on during device reset");
  a_map_normal: assert property (held_low |=> !seg_remap && !com_reverse)
    else $error("mapping not normal during device reset");
  a_contrast_dflt: assert property (held_low |=> contrast == 8'h7F)
    else $error("contrast not default");
  a_start_col: assert property (held_low |=> start_line == 6'h00 && col_addr == 7'h00)
    else $error("start line or column not zero");
  a_normal_mode: assert property (held_low |=> !entire_on)
    else $error("entire display on during reset");
  a_full_rows: assert property (mux_ratio == 6'h3F)
    else $error("mux ratio not 64 rows");
  a_hold_dflt: assert property (!chip_init_in_n [*5] |-> $stable(contrast) && $stable(start_line))
    else $error("state moved during device reset");
  a_cmd_taken: assert property (chip_init_in_n [*4] ##0 (avs_write && !avs_waitrequest &&
    avs_address == 3'h0 && avs_writedata[7:0] == 8'hAF) |=> display_on)
    else $error("display on command not taken");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  cover property (held_low);
  cover property (avs_write && !avs_waitrequest);
  cover property (display_on && entire_on);
endmodule
bind ops_sequencer ops_sequencer_properties ops_sequencer_properties_i (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .chip_init_in_n(chip_init_in_n), .display_on(display_on), .entire_on(entire_on),
  .seg_remap(seg_remap), .com_reverse(com_reverse), .contrast(contrast),
  .start_line(start_line), .col_addr(col_addr), .mux_ratio(mux_ratio));

// File: verification/tb_ops_sequencer.sv
// Self-checking bench for the display sequencer
`timescale 1ns/10ps
module tb_ops_sequencer;
  import ops_pkg::*;
  logic        core_clk, rst, chip_init_in_n, avs_read, avs_write, avs_waitrequest;
  logic        ser_clk, ser_data, ser_sel_n, display_on, entire_on, seg_remap, com_reverse;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  contrast;
  logic [5:0]  start_line, mux_ratio;
  logic [6:0]  col_addr;
  logic [7:0]  cmds [12];
  int          mismatches, samples_checked, e;
  int          m_disp, m_ent, m_seg, m_com, m_contr, m_start, m_col, m_rst, m_arg;

  ops_sequencer ops_sequencer_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .chip_init_in_n(chip_init_in_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_sel_n(ser_sel_n), .display_on(display_on), .entire_on(entire_on),
    .seg_remap(seg_remap), .com_reverse(com_reverse), .contrast(contrast),
    .start_line(start_line), .col_addr(col_addr), .mux_ratio(mux_ratio));
  ops_host_model ops_host_model_i (.core_clk(core_clk), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_sel_n(ser_sel_n));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic model(input logic [7:0] b);
    if (m_arg) begin
      m_contr = b;
      m_arg   = 0;
    end
    else if (b[7:1] == 7'h57 || b[7:1] == 7'h52 || b[7:1] == 7'h50)
      case (b[3:1])
        3'h7: m_disp = b[0];
        3'h2: m_ent = b[0];
        default: m_seg = b[0];
      endcase
    else if (b == 8'hC0 || b == 8'hC8)
      m_com = b[3];
    else if (b == 8'h81)
      m_arg = 1;
    else if (b[7:6] == 2'b01)
      m_start = b[5:0];
  endtask

  task automatic check_all;
    bus(1'b0, OPS_REG_STATUS, 32'h0);
    e = m_disp | m_seg << 1 | m_com << 2 | m_ent << 3 | m_rst << 4 | m_arg << 5;
    chk(rd, e | m_contr << 8 | m_start << 16);
    bus(1'b0, OPS_REG_CONFIG, 32'h0);
    chk(rd, m_col | 32'h803F00);
    chk(mux_ratio, 32'h3F);
    e = {m_disp[0], m_ent[0], m_seg[0], m_com[0], m_contr[7:0], m_start[5:0], m_col[6:0]};
    chk({display_on, entire_on, seg_remap, com_reverse, contrast, start_line, col_addr}, e);
  endtask

  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    rst = 1'b1;
    chip_init_in_n = 1'b1;
    {m_disp, m_ent, m_seg, m_com, m_start, m_col, m_rst, m_arg} = '0;
    m_contr = 8'h7F;
    rd = $urandom(32'h1479);
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    check_all;
    cmds = '{8'hAE, 8'hA1, 8'hC8, 8'h81, 8'h00, 8'h40, 8'hA5, 8'hAF, 8'hA4, 8'hA0, 8'hC0, 8'hAE};
    cmds[4] = 8'($urandom) & 8'h7F;
    cmds[5] = 8'h40 | 8'($urandom_range(63));
    // off, setup, random fill, settle, on, later off
    for (int i = 0; i < 12; i++) begin
      if (i == 7) begin
        for (int k = $urandom_range(130, 126); k > 0; k--) begin
          bus(1'b1, OPS_REG_DATA, $urandom);
          m_col = (m_col + 1) % 128;
        end
        repeat (20) @(posedge core_clk);
      end
      if (i % 2)
        bus(1'b1, OPS_REG_CMD, {24'h0, cmds[i]});
      else begin
        ops_host_model_i.send(cmds[i], 8, 1'b0);
        repeat (8) @(posedge core_clk);
        bus(1'b0, OPS_REG_SERIAL, 32'h0);
        chk(rd, cmds[i]);
      end
      model(cmds[i]);
      check_all;
    end
    // settle wait before the reset pin is pulled low
    repeat (20) @(posedge core_clk);
    for (int i = 5; i < 8; i++) begin
      bus(1'b1, OPS_REG_CMD, {24'h0, cmds[i]});
      model(cmds[i]);
    end
    ops_host_model_i.send(8'hFF, 4, 1'b1);
    chip_init_in_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    bus(1'b1, OPS_REG_CMD, 32'hAF);
    {m_disp, m_ent, m_seg, m_com, m_start, m_col, m_arg} = '0;
    m_contr = 8'h7F;
    m_rst = 1;
    check_all;
    chip_init_in_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    m_rst = 0;
    ops_host_model_i.send(8'hA1, 8, 1'b0);
    repeat (8) @(posedge core_clk);
    model(8'hA1);
    bus(1'b0, OPS_REG_SERIAL, 32'h0);
    chk(rd, 32'hA1);
    check_all;
    end_sim;
  end

  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
endmodule
